//--- src/btc_exec.sv
// Execution unit for bit test/skip, test-then-set, toggle and call forms.
// Assumes decode delivers the operand already read and holds issue until ready.
//
// Behaviour
// RULE1: Skip-if-clear skips the next instruction when the chosen bit is 0, costs 1 or 2/3 cycles, no flags.
// RULE2: Skip-if-set skips when the chosen bit is 1, with the same cost and no flag change.
// RULE3: Test-then-set to carry copies the bit into C, sets the bit, one cycle, only C changes.
// RULE4: Test-then-set to zero puts the bit test into Z, sets the bit, one cycle, only Z changes.
// RULE5: Every call form takes 4 cycles and updates the stack frame active flag; literal form is two words.
// RULE6: Plain bit test writes the inverted bit to Z leaving data alone; toggle inverts the bit with no flags.
// RULE7: A read or read-modify-write bit operation on a peripheral register costs one more cycle.
`timescale 1ns/1ns
module btc_exec
    import btc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Issue from decode
    input wire logic issue_i,
    input wire btc_op_type op_i,
    input wire logic [BIT_IDX_W-1:0] bit_idx_i,
    input wire logic [DATA_W-1:0] operand_i,
    input wire logic [HI_W-1:0] operand_hi_i,
    input wire logic [TARGET_W-1:0] target_lit_i,
    input wire logic sfr_i,
    input wire logic next_two_word_i,
    input wire logic sfa_set_i,
    // Results
    output logic ready_o,
    output logic done_o,
    output logic wb_en_o,
    output logic [DATA_W-1:0] wb_data_o,
    output logic c_we_o,
    output logic c_o,
    output logic z_we_o,
    output logic z_o,
    output logic skip_o,
    output logic skip_two_o,
    output logic call_o,
    output logic [1:0] call_words_o,
    output logic [TARGET_W-1:0] call_target_o,
    output logic sfa_o
);

    typedef struct packed {
        btc_state_type state;
        logic [CNT_W-1:0] cnt;
        logic ready;
        logic done;
        logic wb_en;
        logic [DATA_W-1:0] wb_data;
        logic c_we;
        logic c;
        logic z_we;
        logic z;
        logic skip;
        logic skip_two;
        logic call;
        logic [1:0] call_words;
        logic [TARGET_W-1:0] target;
        logic stack_frame_active_flag;
    } btc_regs_type;

    btc_regs_type st_r;
    btc_regs_type st_nxt;
    btc_bit_if bit_bus ();

    logic take;
    logic is_call;
    logic is_skip;
    logic do_skip;
    logic [CNT_W-1:0] cost;

    assign bit_bus.operand = operand_i;
    assign bit_bus.bit_idx = bit_idx_i;
    assign bit_bus.op = op_i;

    btc_bit_unit btc_bit_unit_i (
        .bus(bit_bus)
    );

    assign take = issue_i && st_r.ready;
    assign is_call = (op_i == OP_CALL_LIT) || (op_i == OP_CALL_IND) || (op_i == OP_CALL_LONG);
    assign is_skip = (op_i == OP_SKIP_CLEAR) || (op_i == OP_SKIP_SET);
    assign do_skip = ((op_i == OP_SKIP_CLEAR) && !bit_bus.tested) ||
                     ((op_i == OP_SKIP_SET) && bit_bus.tested); // RULE1 RULE2

    // ********************
    // Cycle cost
    // ********************
    always_comb begin
        if (is_call) begin
            cost = CALL_CYCLES; // RULE5
        end else if (do_skip) begin
            cost = next_two_word_i ? SKIP_TWO_WORD_CYCLES : SKIP_ONE_WORD_CYCLES; // RULE1 RULE2
        end else begin
            cost = BASE_CYCLES;
        end
        // Call operands come from core registers, so no peripheral penalty
        if (sfr_i && !is_call && op_i != OP_NONE) begin
            cost = cost + SFR_EXTRA_CYCLES; // RULE7
        end
    end

    // ********************
    // Next state
    // ********************
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.wb_en = 1'b0;
        st_nxt.c_we = 1'b0;
        st_nxt.z_we = 1'b0;
        st_nxt.skip = 1'b0;
        st_nxt.call = 1'b0;
        if (sfa_set_i) begin
            st_nxt.stack_frame_active_flag = 1'b1;
        end
        case (st_r.state)
            ST_IDLE: begin
                if (take && op_i != OP_NONE) begin
                    st_nxt.done = 1'b1;
                    st_nxt.wb_data = bit_bus.result;
                    st_nxt.skip = do_skip;
                    st_nxt.skip_two = do_skip && next_two_word_i;
                    case (op_i)
                        OP_TEST_F, OP_TEST_Z: begin
                            st_nxt.z_we = 1'b1; // RULE6
                            st_nxt.z = ~bit_bus.tested;
                        end
                        OP_TEST_C: begin
                            st_nxt.c_we = 1'b1;
                            st_nxt.c = bit_bus.tested;
                        end
                        OP_TTS_C: begin
                            st_nxt.c_we = 1'b1; // RULE3
                            st_nxt.c = bit_bus.tested;
                            st_nxt.wb_en = 1'b1;
                        end
                        OP_TTS_Z, OP_TTS_F: begin
                            st_nxt.z_we = 1'b1; // RULE4
                            st_nxt.z = ~bit_bus.tested;
                            st_nxt.wb_en = 1'b1;
                        end
                        OP_TOGGLE: begin
                            st_nxt.wb_en = 1'b1; // RULE6
                        end
                        OP_CALL_LIT: begin
                            st_nxt.call = 1'b1; // RULE5
                            st_nxt.call_words = CALL_LIT_WORDS;
                            st_nxt.target = target_lit_i;
                            st_nxt.stack_frame_active_flag = 1'b0;
                        end
                        OP_CALL_IND: begin
                            st_nxt.call = 1'b1; // RULE5
                            st_nxt.call_words = CALL_IND_WORDS;
                            st_nxt.target = {{HI_W{1'b0}}, operand_i};
                            st_nxt.stack_frame_active_flag = 1'b0;
                        end
                        OP_CALL_LONG: begin
                            st_nxt.call = 1'b1; // RULE5
                            st_nxt.call_words = CALL_IND_WORDS;
                            st_nxt.target = {operand_hi_i, operand_i};
                            st_nxt.stack_frame_active_flag = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                    // Stall for the cycles beyond the first
                    if (cost > BASE_CYCLES) begin
                        st_nxt.state = ST_STALL;
                        st_nxt.cnt = cost - BASE_CYCLES;
                        st_nxt.ready = 1'b0;
                    end
                end
            end
            ST_STALL: begin
                st_nxt.cnt = st_r.cnt - 3'h1;
                if (st_r.cnt == 3'h1) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.ready = 1'b1;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.state <= ST_IDLE;
            st_r.cnt <= CNT_RESET;
            st_r.ready <= 1'b1;
            st_r.stack_frame_active_flag <= SFA_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ready_o = st_r.ready;
    assign done_o = st_r.done;
    assign wb_en_o = st_r.wb_en;
    assign wb_data_o = st_r.wb_data;
    assign c_we_o = st_r.c_we;
    assign c_o = st_r.c;
    assign z_we_o = st_r.z_we;
    assign z_o = st_r.z;
    assign skip_o = st_r.skip;
    assign skip_two_o = st_r.skip_two;
    assign call_o = st_r.call;
    assign call_words_o = st_r.call_words;
    assign call_target_o = st_r.target;
    assign sfa_o = st_r.stack_frame_active_flag;

    // ********************
    // Checks
    // ********************
    property p_skip_clear;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_SKIP_CLEAR && !sfr_i |->
            (!bit_bus.tested ##1 skip_o && !c_we_o && !z_we_o) or
            (bit_bus.tested ##1 !skip_o && ready_o);
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("skip if clear wrong"); // RULE1

    property p_skip_set_two;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_SKIP_SET && bit_bus.tested && next_two_word_i && !sfr_i |=>
            skip_o && skip_two_o && !ready_o ##1 !ready_o ##1 ready_o;
    endproperty
    a_skip_set_two: assert property (p_skip_set_two) else $error("skip if set timing wrong"); // RULE2

    property p_tts_c;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_TTS_C && !sfr_i |=>
            c_we_o && c_o == $past(operand_i[bit_idx_i]) && !z_we_o && wb_en_o &&
            wb_data_o[$past(bit_idx_i)] && ready_o;
    endproperty
    a_tts_c: assert property (p_tts_c) else $error("test then set carry wrong"); // RULE3

    property p_tts_z;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_TTS_Z |=>
            z_we_o && z_o == !$past(operand_i[bit_idx_i]) && !c_we_o && wb_data_o[$past(bit_idx_i)];
    endproperty
    a_tts_z: assert property (p_tts_z) else $error("test then set zero wrong"); // RULE4

    property p_call;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && is_call && !sfa_set_i |=>
            call_o && !sfa_o && !ready_o ##1 !ready_o [*2] ##1 ready_o;
    endproperty
    a_call: assert property (p_call) else $error("call not four cycles"); // RULE5

    property p_test_only;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_TEST_F |=> z_we_o && z_o != $past(bit_bus.tested) && !wb_en_o;
    endproperty
    a_test_only: assert property (p_test_only) else $error("bit test wrong"); // RULE6

    property p_toggle;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && op_i == OP_TOGGLE |=>
            wb_en_o && (wb_data_o ^ $past(operand_i)) == (16'h0001 << $past(bit_idx_i)) &&
            !c_we_o && !z_we_o;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle wrong"); // RULE6

    property p_sfr;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        take && sfr_i && (op_i == OP_TOGGLE || op_i == OP_TEST_F) |=> !ready_o ##1 ready_o;
    endproperty
    a_sfr: assert property (p_sfr) else $error("peripheral penalty wrong"); // RULE7

endmodule

//--- inc/btc_pkg.sv
// Constants and types for the bit-test and call execution block.
// Assumes a single core instruction clock and a synchronous reset.
package btc_pkg;

    localparam int DATA_W = 16;
    localparam int BIT_IDX_W = 4;
    localparam int TARGET_W = 23;
    localparam int HI_W = TARGET_W - DATA_W;
    localparam int CNT_W = 3;

    // Cycle costs per instruction form
    localparam logic [CNT_W-1:0] BASE_CYCLES = 3'h1;
    localparam logic [CNT_W-1:0] SKIP_ONE_WORD_CYCLES = 3'h2;
    localparam logic [CNT_W-1:0] SKIP_TWO_WORD_CYCLES = 3'h3;
    localparam logic [CNT_W-1:0] CALL_CYCLES = 3'h4;
    localparam logic [CNT_W-1:0] SFR_EXTRA_CYCLES = 3'h1;

    // Words occupied by each call form
    localparam logic [1:0] CALL_LIT_WORDS = 2'h2;
    localparam logic [1:0] CALL_IND_WORDS = 2'h1;

    // Reset values
    localparam logic SFA_RESET = 1'b0;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SKIP_CLEAR = 4'h1,
        OP_SKIP_SET = 4'h2,
        OP_TEST_F = 4'h3,
        OP_TEST_C = 4'h4,
        OP_TEST_Z = 4'h5,
        OP_TTS_F = 4'h6,
        OP_TTS_C = 4'h7,
        OP_TTS_Z = 4'h8,
        OP_TOGGLE = 4'h9,
        OP_CALL_LIT = 4'ha,
        OP_CALL_IND = 4'hb,
        OP_CALL_LONG = 4'hc
    } btc_op_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_STALL = 1'b1
    } btc_state_type;

endpackage

//--- inc/btc_bit_if.sv
// Interface between the sequencer and the single-bit datapath.
// Purely combinational signals within one clock domain.
`timescale 1ns/1ns
interface btc_bit_if;
    import btc_pkg::*;
    logic [DATA_W-1:0] operand;
    logic [BIT_IDX_W-1:0] bit_idx;
    btc_op_type op;
    logic tested;
    logic [DATA_W-1:0] result;

    modport alu (input operand, input bit_idx, input op, output tested, output result);
    modport ctl (output operand, output bit_idx, output op, input tested, input result);
endinterface

//--- src/btc_bit_unit.sv
// Single-bit datapath: picks the tested bit and forms the write-back word.
// Assumes operand and bit index are stable for the issuing cycle.
`timescale 1ns/1ns
module btc_bit_unit
    import btc_pkg::*;
(
    btc_bit_if.alu bus
);

    assign bus.tested = bus.operand[bus.bit_idx];

    // ********************
    // Per-bit result
    // ********************
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
        always_comb begin
            if (bus.bit_idx == BIT_IDX_W'(i)) begin
                case (bus.op)
                    OP_TOGGLE: bus.result[i] = ~bus.operand[i];
                    OP_TTS_F, OP_TTS_C, OP_TTS_Z: bus.result[i] = 1'b1;
                    default: bus.result[i] = bus.operand[i];
                endcase
            end else begin
                bus.result[i] = bus.operand[i];
            end
        end
    end

endmodule

//--- verif/btc_fetch_model.sv
// Fetch stage model on the far side of the execution block.
// Assumes one clock with the block; follows its skip and call pulses.
`timescale 1ns/1ns
module btc_fetch_model
    import btc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Control from the execution block
    input wire logic skip_i,
    input wire logic skip_two_i,
    input wire logic call_i,
    input wire logic [TARGET_W-1:0] call_target_i,
    // Program counter in words
    output logic [TARGET_W-1:0] pc_o
);
    // Only flow changes are tracked, not sequential fetch
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pc_o <= '0;
        end else if (call_i) begin
            pc_o <= call_target_i;
        end else if (skip_i) begin
            pc_o <= pc_o + (skip_two_i ? 23'h2 : 23'h1);
        end
    end
endmodule

//--- verif/bit_test_call_exec_test.sv
// Self-checking bench for the bit-test and call execution block.
// Assumes the package constants; drives at falling edges only.
`timescale 1ns/1ns
module bit_test_call_exec_test
    import btc_pkg::*;
;
    logic ref_clk_i, sys_rst_i, issue_i, sfr_i, next_two_word_i, sfa_set_i;
    btc_op_type op_i;
    logic [3:0] bit_idx_i;
    logic [15:0] operand_i;
    logic [6:0] operand_hi_i;
    logic [22:0] target_lit_i, call_target_o, pc, exp_pc;
    logic ready_o, done_o, wb_en_o, c_we_o, c_o, z_we_o, z_o;
    logic skip_o, skip_two_o, call_o, sfa_o;
    logic [15:0] wb_data_o;
    logic [1:0] call_words_o;
    int n_mismatch = 0;
    int checked = 0;

    btc_exec btc_exec_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .issue_i(issue_i),
        .op_i(op_i), .bit_idx_i(bit_idx_i), .operand_i(operand_i),
        .operand_hi_i(operand_hi_i), .target_lit_i(target_lit_i), .sfr_i(sfr_i),
        .next_two_word_i(next_two_word_i), .sfa_set_i(sfa_set_i), .ready_o(ready_o),
        .done_o(done_o), .wb_en_o(wb_en_o), .wb_data_o(wb_data_o), .c_we_o(c_we_o),
        .c_o(c_o), .z_we_o(z_we_o), .z_o(z_o), .skip_o(skip_o), .skip_two_o(skip_two_o),
        .call_o(call_o), .call_words_o(call_words_o), .call_target_o(call_target_o),
        .sfa_o(sfa_o));
    btc_fetch_model btc_fetch_model_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .skip_i(skip_o), .skip_two_i(skip_two_o), .call_i(call_o),
        .call_target_i(call_target_o), .pc_o(pc));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Issue one op; p holds {done,wb_en,c_we,z_we,skip,skip_two,call}
    task automatic run(input btc_op_type op, input logic [3:0] idx, input logic [15:0] d,
            input logic s, input logic t, output logic [6:0] p, output int cost);
        op_i = op;
        bit_idx_i = idx;
        operand_i = d;
        sfr_i = s;
        next_two_word_i = t;
        issue_i = 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        issue_i = 1'b0;
        p = {done_o, wb_en_o, c_we_o, z_we_o, skip_o, skip_two_o, call_o};
        cost = 1;
        while (ready_o !== 1'b1 && cost < 9) begin
            @(negedge ref_clk_i);
            cost++;
        end
        if (cost >= 9) begin
            n_mismatch++;
            conclude();
        end
        // Let an edge pass so issue_i never falls and rises in one step
        @(negedge ref_clk_i);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_skip();
        logic [15:0] m;
        logic [6:0] p;
        int c;
        logic tk;
        for (int i = 0; i < 8; i++) begin
            m = 16'h1 << (15 - 2 * i);
            tk = (i[2] == i[1]);
            run(i[2] ? OP_SKIP_SET : OP_SKIP_CLEAR, 4'(15 - 2 * i), i[1] ? m : ~m, 1'b0,
                i[0], p, c);
            chk("skip pulses", {1'b1, 3'h0, tk, tk & i[0], 1'b0}, p);
            chk("skip cost", tk ? (i[0] ? SKIP_TWO_WORD_CYCLES : SKIP_ONE_WORD_CYCLES)
                : BASE_CYCLES, c);
            if (tk) exp_pc = exp_pc + (i[0] ? 23'h2 : 23'h1);
            chk("fetch pc", exp_pc, pc);
        end
    endtask

    task automatic t_bitops();
        btc_op_type ops [7] = '{OP_TTS_C, OP_TTS_Z, OP_TTS_F, OP_TEST_C, OP_TEST_Z,
            OP_TEST_F, OP_TOGGLE};
        logic [15:0] m, d;
        logic [6:0] p;
        int c;
        logic cy, wb, b;
        for (int j = 0; j < 7; j++) begin
            m = 16'h1 << (2 * j + 1);
            b = j[0];
            d = b ? (16'ha5c3 | m) : (16'ha5c3 & ~m);
            cy = ops[j] inside {OP_TTS_C, OP_TEST_C};
            wb = ops[j] inside {OP_TTS_C, OP_TTS_Z, OP_TTS_F, OP_TOGGLE};
            run(ops[j], 4'(2 * j + 1), d, 1'b0, 1'b0, p, c);
            if (ops[j] == OP_TOGGLE) begin
                chk("toggle pulses", 7'h60, p);
                chk("toggle data", d ^ m, wb_data_o);
            end else begin
                chk("test pulses", {1'b1, wb, cy, ~cy, 3'h0}, p);
                chk("test flag", cy ? b : !b, cy ? c_o : z_o);
                if (wb) chk("set data", d | m, wb_data_o);
            end
            chk("bit op cost", BASE_CYCLES, c);
        end
    endtask

    task automatic t_call();
        logic [6:0] p;
        int c;
        logic [22:0] tg [3] = '{23'h7abcde, 23'h00beef, 23'h2a1234};
        btc_op_type ops [3] = '{OP_CALL_LIT, OP_CALL_IND, OP_CALL_LONG};
        target_lit_i = tg[0];
        operand_hi_i = tg[2][22:16];
        for (int k = 0; k < 3; k++) begin
            sfa_set_i = 1'b1;
            @(negedge ref_clk_i);
            sfa_set_i = 1'b0;
            chk("frame flag set", 1'b1, sfa_o);
            run(ops[k], 4'h0, tg[k][15:0], 1'b1, 1'b1, p, c);
            chk("call pulses", 7'h41, p);
            chk("call cost", CALL_CYCLES, c);
            chk("call words", k == 0 ? CALL_LIT_WORDS : CALL_IND_WORDS, call_words_o);
            chk("call target", tg[k], call_target_o);
            chk("frame flag", 1'b0, sfa_o);
            chk("fetch pc", tg[k], pc);
        end
    endtask

    task automatic t_sfr();
        logic [6:0] p;
        int c;
        run(OP_TOGGLE, 4'h0, 16'h0001, 1'b1, 1'b0, p, c);
        chk("sfr toggle cost", BASE_CYCLES + SFR_EXTRA_CYCLES, c);
        run(OP_TEST_C, 4'h3, 16'h0008, 1'b1, 1'b0, p, c);
        chk("sfr test cost", BASE_CYCLES + SFR_EXTRA_CYCLES, c);
        run(OP_SKIP_SET, 4'h3, 16'h0008, 1'b1, 1'b0, p, c);
        chk("sfr skip cost", SKIP_ONE_WORD_CYCLES + SFR_EXTRA_CYCLES, c);
        exp_pc = exp_pc + 23'h1;
        chk("sfr skip pc", exp_pc, pc);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        {sys_rst_i, issue_i, sfr_i, next_two_word_i, sfa_set_i} = 5'h10;
        op_i = OP_NONE;
        bit_idx_i = 4'h0;
        operand_i = 16'h0;
        operand_hi_i = 7'h0;
        target_lit_i = 23'h0;
        exp_pc = 23'h0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        chk("reset outputs", {1'b1, SFA_RESET, 1'b0}, {ready_o, sfa_o, done_o});
        t_skip();
        t_bitops();
        t_sfr();
        t_call();
        conclude();
    end
endmodule
